/* File: shared/usf_pkg.sv */
// Constants for the serial receiver/transmitter status flag block
// What this block does
// - Transmit-empty bit 1 rises when holding data moves to shifter, falls on write.
// - Carrier-loss bit 2 goes high when the carrier-detect input goes high.
// - Carrier-loss rising with receive interrupt enable set raises an interrupt request.
// - Carrier-loss stays latched; clears by status read then data read, or master reset.
// - If carrier input still high after clearing, interrupt drops, bit follows input.
// - Bit 3 mirrors the clear-to-send input; low means transmission permitted.
// - Clear-to-send high inhibits transmit-empty and shows bit 3 high.
// - Master reset leaves the clear-to-send status bit tracking its input.
// - Framing-error bit 4 sets when the first stop bit is missing.
// - Framing error updates on transfer into receive register, held while character stays.
// - Overrun starts at second unread character's last-bit midpoint; reported in bit 5.
// - Overrun shows only after the valid character before it has been read.
// - During overrun receive-full stays set until cleared; character sync is kept.
// - Overrun clears on receive data register read or master reset.
// - Parity-error bit 6 sets when ones count disagrees with selected parity.
// - Parity error stays while its character is held in the receive register.
// - No-parity formats suppress transmit parity output and receive parity check.
// - Bit 7 reads high whenever the interrupt output is asserted.
// - Receive data read or transmit data write releases the interrupt output and bit.
// - Both divide-select bits high give master reset, clearing all but input states.
// - Control bit 7 enables receive-full, overrun and carrier-rise interrupts.
// - Receive-full bit 0 clears on receive data read or master reset.
package usf_pkg;

    // ****************************************
    // Status register bit positions
    // ****************************************
    localparam int STAT_RX_FULL    = 0;
    localparam int STAT_TX_EMPTY   = 1;
    localparam int STAT_CARRIER    = 2;
    localparam int STAT_CTS        = 3;
    localparam int STAT_FRAMING    = 4;
    localparam int STAT_OVERRUN    = 5;
    localparam int STAT_PARITY     = 6;
    localparam int STAT_IRQ        = 7;

    // ****************************************
    // Control register fields
    // ****************************************
    localparam int CTRL_DIV_LO     = 0;
    localparam int CTRL_DIV_HI     = 1;
    localparam int CTRL_WORD_LO    = 2;
    localparam int CTRL_TXC_LO     = 5;
    localparam int CTRL_RX_IE      = 7;
    localparam logic [1:0] DIV_MASTER_RESET = 2'h3;
    localparam logic [1:0] TXC_TX_IRQ_EN    = 2'h1;
    localparam logic [2:0] WORD_8N2         = 3'h4;
    localparam logic [2:0] WORD_8N1         = 3'h5;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0] CTRL_RESET  = 8'h03;
    localparam logic [7:0] DATA_RESET  = 8'h00;

endpackage

/* File: hdl/usf_parity.sv */
// Parity generator and checker shared by both data directions
`timescale 1ns/10ps
`default_nettype none

module usf_parity #(
    parameter int WIDTH = 8
) (
    // Character and format
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_eight_bits,
    input  wire logic             i_odd,
    input  wire logic             i_enable,
    // Results
    output logic                  o_parity_bit,
    output logic                  o_bit_ones_odd
);

    logic [WIDTH-1:0] masked;

    // Seven-bit formats ignore the top data bit
    always_comb begin
        masked = i_data;
        if (!i_eight_bits) begin
            masked[WIDTH-1] = 1'b0;
        end
    end

    // Parity bit makes the total count of ones odd or even; forced low when off
    assign o_bit_ones_odd = ^masked;
    assign o_parity_bit   = i_enable & (o_bit_ones_odd ^ i_odd);

endmodule
`default_nettype wire

/* File: hdl/usf_flags.sv */
// Status flags, control register and data holding registers of the serial block
`timescale 1ns/10ps
`default_nettype none

module usf_flags (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    // Processor bus: one-cycle access strobe
    input  wire logic       i_access,
    input  wire logic       i_register_select,
    input  wire logic       i_read,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    output logic            o_data_oe,
    output logic            o_irq_b,
    // Modem control inputs
    input  wire logic       i_carrier_b,
    input  wire logic       i_clear_to_send_b,
    // Receiver deserialiser side
    input  wire logic       i_rx_done,
    input  wire logic [7:0] i_rx_char,
    input  wire logic       i_rx_parity_bit,
    input  wire logic       i_rx_stop_ok,
    // Transmitter serialiser side
    input  wire logic       i_tx_load,
    output logic      [7:0] o_tx_data,
    output logic            o_tx_parity_bit,
    output logic            o_tx_pending,
    // Control outputs to divider and shifters
    output logic      [1:0] o_divide_select,
    output logic      [2:0] o_word_select,
    output logic      [1:0] o_tx_control,
    output logic            o_master_reset
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] control;
    logic [7:0] next_control;
    logic [7:0] rx_holding_register;
    logic [7:0] next_rx_holding_register;
    logic [7:0] tx_holding_register;
    logic [7:0] next_tx_holding_register;
    logic       rx_holding_full;
    logic       next_rx_holding_full;
    logic       tx_holding_empty;
    logic       next_tx_holding_empty;
    logic       framing_error;
    logic       next_framing_error;
    logic       parity_error;
    logic       next_parity_error;
    logic       overrun_pending;
    logic       next_overrun_pending;
    logic       receive_overrun;
    logic       next_receive_overrun;
    logic       carrier_latch;
    logic       next_carrier_latch;
    logic       carrier_irq;
    logic       next_carrier_irq;
    logic       clear_marker;
    logic       next_clear_marker;
    logic       carrier_prev;
    logic       carrier_now;
    logic       cts_now;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       data_oe;
    logic       next_data_oe;
    logic       irq_b;
    logic       next_irq_b;
    logic       tx_parity;
    logic       next_tx_parity;

    logic       master_reset;
    logic       eight_bits;
    logic       parity_on;
    logic       odd_sel;
    logic       rx_ones_odd;
    logic       tx_par_bit;
    logic       status_read;
    logic       rdr_read;
    logic       ctrl_write;
    logic       tdr_write;
    logic       carrier_rise;
    logic       irq_cond;
    logic [7:0] status_word;

    localparam int CTRL_DIV_LO  = usf_pkg::CTRL_DIV_LO;
    localparam int CTRL_DIV_HI  = usf_pkg::CTRL_DIV_HI;
    localparam int CTRL_WORD_LO = usf_pkg::CTRL_WORD_LO;
    localparam int CTRL_TXC_LO  = usf_pkg::CTRL_TXC_LO;
    localparam int CTRL_RX_IE   = usf_pkg::CTRL_RX_IE;

    // ****************************************
    // Decode of bus access and format
    // ****************************************
    assign status_read  = i_access & i_read & ~i_register_select;
    assign rdr_read     = i_access & i_read & i_register_select;
    assign ctrl_write   = i_access & ~i_read & ~i_register_select;
    assign tdr_write    = i_access & ~i_read & i_register_select;
    assign master_reset = (control[CTRL_DIV_HI:CTRL_DIV_LO] == usf_pkg::DIV_MASTER_RESET);
    assign eight_bits   = control[CTRL_WORD_LO+2];
    assign parity_on    = (control[CTRL_WORD_LO+2:CTRL_WORD_LO] != usf_pkg::WORD_8N2)
                        & (control[CTRL_WORD_LO+2:CTRL_WORD_LO] != usf_pkg::WORD_8N1);
    assign odd_sel      = control[CTRL_WORD_LO];
    assign carrier_rise = carrier_now & ~carrier_prev;

    // ****************************************
    // Parity for both directions
    // ****************************************
    usf_parity #(
        .WIDTH          (8)
    ) u_rx_parity (
        .i_data         (i_rx_char),
        .i_eight_bits   (eight_bits),
        .i_odd          (odd_sel),
        .i_enable       (parity_on),
        .o_parity_bit   (),
        .o_bit_ones_odd (rx_ones_odd)
    );

    usf_parity #(
        .WIDTH          (8)
    ) u_tx_parity (
        .i_data         (tx_holding_register),
        .i_eight_bits   (eight_bits),
        .i_odd          (odd_sel),
        .i_enable       (parity_on),
        .o_parity_bit   (tx_par_bit),
        .o_bit_ones_odd ()
    );

    // ****************************************
    // Control and transmit holding register
    // ****************************************
    always_comb begin
        next_control             = control;
        next_tx_holding_register = tx_holding_register;
        next_tx_holding_empty    = tx_holding_empty;
        next_tx_parity           = tx_par_bit;
        if (ctrl_write) begin
            next_control = i_wdata;
        end
        // Shifter took the data: holding register free again
        if (i_tx_load && !tx_holding_empty) begin
            next_tx_holding_empty = 1'b1;
        end
        // A new write refills it; it beats a load in the same cycle
        if (tdr_write) begin
            next_tx_holding_register = i_wdata;
            next_tx_holding_empty    = 1'b0;
        end
        if (master_reset) begin
            next_tx_holding_empty = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            control             <= usf_pkg::CTRL_RESET;
            tx_holding_register <= usf_pkg::DATA_RESET;
            tx_holding_empty    <= 1'b1;
            tx_parity           <= 1'b0;
        end else begin
            control             <= next_control;
            tx_holding_register <= next_tx_holding_register;
            tx_holding_empty    <= next_tx_holding_empty;
            tx_parity           <= next_tx_parity;
        end
    end

    // ****************************************
    // Receive holding register and error flags
    // ****************************************
    // Overrun is held pending until the character in front of it is read,
    // so software always gets the last good character first.
    always_comb begin
        next_rx_holding_register = rx_holding_register;
        next_rx_holding_full     = rx_holding_full;
        next_framing_error       = framing_error;
        next_parity_error        = parity_error;
        next_overrun_pending     = overrun_pending;
        next_receive_overrun     = receive_overrun;
        if (rdr_read) begin
            if (overrun_pending) begin
                next_receive_overrun = 1'b1;
                next_overrun_pending = 1'b0;
            end else begin
                next_rx_holding_full = 1'b0;
                next_receive_overrun = 1'b0;
            end
        end
        if (i_rx_done && !carrier_now) begin
            if (rx_holding_full && !(rdr_read && !overrun_pending && !receive_overrun)) begin
                next_overrun_pending = 1'b1;
            end else begin
                next_rx_holding_register = eight_bits ? i_rx_char : {1'b0, i_rx_char[6:0]};
                next_rx_holding_full     = 1'b1;
                next_framing_error       = ~i_rx_stop_ok;
                next_parity_error        = parity_on
                                         & ((rx_ones_odd ^ i_rx_parity_bit) != odd_sel);
            end
        end
        // Lost carrier shows the register as empty; data stays
        if (carrier_now) begin
            next_rx_holding_full = 1'b0;
        end
        if (master_reset) begin
            next_rx_holding_full = 1'b0;
            next_framing_error   = 1'b0;
            next_parity_error    = 1'b0;
            next_overrun_pending = 1'b0;
            next_receive_overrun = 1'b0;
        end
    end

    // Framing and parity flags change only on a transfer or master reset, so they live as long as the character
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_holding_register <= usf_pkg::DATA_RESET;
            rx_holding_full     <= 1'b0;
            framing_error       <= 1'b0;
            parity_error        <= 1'b0;
            overrun_pending     <= 1'b0;
            receive_overrun     <= 1'b0;
        end else begin
            rx_holding_register <= next_rx_holding_register;
            rx_holding_full     <= next_rx_holding_full;
            framing_error       <= next_framing_error;
            parity_error        <= next_parity_error;
            overrun_pending     <= next_overrun_pending;
            receive_overrun     <= next_receive_overrun;
        end
    end

    // ****************************************
    // Carrier loss and modem inputs
    // ****************************************
    always_comb begin
        next_carrier_latch = carrier_latch;
        next_carrier_irq   = carrier_irq;
        next_clear_marker  = clear_marker;
        if (status_read && (carrier_latch || carrier_now)) begin
            next_clear_marker = 1'b1;
        end
        if (rdr_read && clear_marker) begin
            next_carrier_latch = 1'b0;
            next_carrier_irq   = 1'b0;
            next_clear_marker  = 1'b0;
        end
        if (master_reset) begin
            next_carrier_latch = 1'b0;
            next_carrier_irq   = 1'b0;
            next_clear_marker  = 1'b0;
        end else if (carrier_rise) begin
            // A new loss of carrier beats a clear in the same cycle
            next_carrier_latch = 1'b1;
            next_carrier_irq   = 1'b1;
        end
    end

    // Modem inputs are sampled once; the reset input clears them, master reset does not
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            carrier_latch <= 1'b0;
            carrier_irq   <= 1'b0;
            clear_marker  <= 1'b0;
            carrier_prev  <= 1'b0;
            carrier_now   <= 1'b0;
            cts_now       <= 1'b0;
        end else begin
            carrier_latch <= next_carrier_latch;
            carrier_irq   <= next_carrier_irq;
            clear_marker  <= next_clear_marker;
            carrier_prev  <= carrier_now;
            carrier_now   <= i_carrier_b;
            cts_now       <= i_clear_to_send_b;
        end
    end

    // ****************************************
    // Interrupt and read data
    // ****************************************
    // Sources clear on the data read or data write, so the request drops with them
    always_comb begin
        irq_cond = (control[CTRL_RX_IE]
                    & (rx_holding_full | receive_overrun | carrier_irq))
                 | ((control[CTRL_TXC_LO+1:CTRL_TXC_LO] == usf_pkg::TXC_TX_IRQ_EN)
                    & tx_holding_empty & ~cts_now);
        status_word = '0;
        status_word[usf_pkg::STAT_RX_FULL]  = rx_holding_full;
        status_word[usf_pkg::STAT_TX_EMPTY] = tx_holding_empty & ~cts_now;
        status_word[usf_pkg::STAT_CARRIER]  = carrier_latch | carrier_now;
        status_word[usf_pkg::STAT_CTS]      = cts_now;
        status_word[usf_pkg::STAT_FRAMING]  = framing_error;
        status_word[usf_pkg::STAT_OVERRUN]  = receive_overrun;
        status_word[usf_pkg::STAT_PARITY]   = parity_error;
        status_word[usf_pkg::STAT_IRQ]      = ~irq_b;
        next_irq_b   = ~irq_cond;
        next_data_oe = i_access & i_read;
        next_rdata   = rdata;
        if (status_read) begin
            next_rdata = status_word;
        end else if (rdr_read) begin
            next_rdata = rx_holding_register;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_b   <= 1'b1;
            data_oe <= 1'b0;
            rdata   <= usf_pkg::DATA_RESET;
        end else begin
            irq_b   <= next_irq_b;
            data_oe <= next_data_oe;
            rdata   <= next_rdata;
        end
    end

    // ****************************************
    // Outputs, all from flip-flops except master reset, decoded from the two divide-select bits
    // ****************************************
    assign o_rdata         = rdata;
    assign o_data_oe       = data_oe;
    assign o_irq_b         = irq_b;
    assign o_tx_data       = tx_holding_register;
    assign o_tx_parity_bit = tx_parity;
    assign o_tx_pending    = ~tx_holding_empty;
    assign o_divide_select = control[CTRL_DIV_HI:CTRL_DIV_LO];
    assign o_word_select   = control[CTRL_WORD_LO+2:CTRL_WORD_LO];
    assign o_tx_control    = control[CTRL_TXC_LO+1:CTRL_TXC_LO];
    assign o_master_reset  = master_reset;

endmodule
`default_nettype wire

/* File: testbench/usf_flags_chk.sv */
// Port-level checker for the status flag block
`timescale 1ns/10ps
`default_nettype none

module usf_flags_chk (
    // Clock, reset and bus
    input wire logic       i_mclk,
    input wire logic       i_rst_b,
    input wire logic       i_access,
    input wire logic       i_register_select,
    input wire logic       i_read,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic       o_irq_b,
    // Modem and shifter side
    input wire logic       i_carrier_b,
    input wire logic       i_clear_to_send_b,
    input wire logic       i_tx_load,
    input wire logic [7:0] o_tx_data,
    input wire logic       o_tx_parity_bit,
    input wire logic       o_tx_pending,
    input wire logic [1:0] o_divide_select,
    input wire logic [2:0] o_word_select,
    input wire logic       o_master_reset
);
    logic [1:0] up_q;
    logic [1:0] next_up;
    logic       st_rd;
    logic       dt_wr;

    // Input flops need two edges after release before status can trust them
    assign next_up = {up_q[0], 1'b1};
    assign st_rd   = i_access && i_read && !i_register_select;
    assign dt_wr   = i_access && !i_read && i_register_select;

    // Edges since reset release
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            up_q <= 2'h0;
        end else begin
            up_q <= next_up;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    // ****
    // Assertions
    // ****
    tx_write_a: assert property (
        dt_wr && !o_master_reset |=> o_tx_pending && o_tx_data == $past(i_wdata))
        else $error("data write not held for transmit");
    tx_load_a: assert property (
        i_tx_load && o_tx_pending && !dt_wr |=> !o_tx_pending)
        else $error("holding register still full after load");
    cts_high_a: assert property (
        st_rd && up_q[1] && $past(i_clear_to_send_b) && $past(i_clear_to_send_b, 2)
        |=> o_rdata[3] && !o_rdata[1]) else $error("send permit high not shown");
    cts_low_a: assert property (
        st_rd && up_q[1] && !$past(i_clear_to_send_b) && !$past(i_clear_to_send_b, 2)
        |=> !o_rdata[3]) else $error("send permit low not shown");
    carrier_bit_a: assert property (
        st_rd && up_q[1] && $past(i_carrier_b) && $past(i_carrier_b, 2)
        |=> o_rdata[2] && !o_rdata[0]) else $error("carrier loss not shown");
    irq_bit_a: assert property (
        st_rd |=> o_rdata[7] == !$past(o_irq_b))
        else $error("interrupt bit differs from output");
    div_reset_a: assert property (
        o_master_reset == (o_divide_select == 2'h3))
        else $error("master reset not tied to divide code");
    par_off_a: assert property (
        up_q[1] && $stable(o_word_select) && o_word_select inside {3'h4, 3'h5}
        |-> !o_tx_parity_bit) else $error("parity bit sent without parity");
    par_on_a: assert property (
        up_q[1] && $stable(o_word_select) && $stable(o_tx_data) && o_word_select[2:1] == 2'h3
        |-> o_tx_parity_bit == (^o_tx_data ^ o_word_select[0]))
        else $error("transmit parity bit wrong");

    // Main scenarios reached
    cover property (st_rd ##1 o_rdata[7]);
    cover property (st_rd ##1 o_rdata[5]);
    cover property (i_tx_load && o_tx_pending);
endmodule
`default_nettype wire

/* File: testbench/usf_far_model.sv */
// Modem lines and shifter stand-in facing the status flag block
`timescale 1ns/10ps
`default_nettype none

module usf_far_model (
    // Clock and holding register state
    input  wire logic       i_mclk,
    input  wire logic       i_slow,
    input  wire logic       i_tx_pending,
    // Modem lines
    output logic            o_carrier_b,
    output logic            o_clear_to_send_b,
    // Deserialiser results
    output logic            o_rx_done,
    output logic      [7:0] o_rx_char,
    output logic            o_rx_parity_bit,
    output logic            o_rx_stop_ok,
    // Serialiser take-up
    output logic            o_tx_load
);
    int unsigned wait_n;

    // Quiet lines at time zero
    initial begin
        {o_carrier_b, o_clear_to_send_b, o_rx_done, o_tx_load} = 4'h0;
        {o_rx_char, o_rx_parity_bit, o_rx_stop_ok} = 10'h0;
        wait_n = 0;
    end

    // Shifter takes the holding register promptly or slowly
    always @(negedge i_mclk) begin
        if (i_tx_pending && !o_tx_load && wait_n >= (i_slow ? 12 : 1)) begin
            o_tx_load <= 1'b1;
            wait_n <= 0;
        end else begin
            o_tx_load <= 1'b0;
            wait_n <= i_tx_pending ? wait_n + 1 : 0;
        end
    end

    // One character per pulse, results released (inverted) after it
    task automatic send_char(input logic [7:0] ch, input logic par, input logic stop);
        @(negedge i_mclk);
        o_rx_done = 1'b1;
        o_rx_char = ch;
        o_rx_parity_bit = par;
        o_rx_stop_ok = stop;
        @(negedge i_mclk);
        o_rx_done = 1'b0;
        o_rx_char = ~ch;
        o_rx_parity_bit = ~par;
        o_rx_stop_ok = ~stop;
    endtask

    // Modem level change
    task automatic set_modem(input logic car, input logic cts);
        @(negedge i_mclk);
        o_carrier_b = car;
        o_clear_to_send_b = cts;
    endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the status flag block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic       i_mclk, i_rst_b, i_access, rs, rd, slow;
    logic [7:0] wd, got, o_rdata, o_tx_data, rx_char, want;
    logic       o_data_oe, o_irq_b, car_b, cts_b, rx_done, rx_par, stop_ok, tx_load;
    logic       o_tx_parity_bit, o_tx_pending, o_master_reset;
    logic [1:0] o_divide_select, o_tx_control;
    logic [2:0] o_word_select;
    int         n_fail, checks;

    usf_flags u_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_access(i_access),
        .i_register_select(rs), .i_read(rd), .i_wdata(wd), .o_rdata(o_rdata),
        .o_data_oe(o_data_oe), .o_irq_b(o_irq_b), .i_carrier_b(car_b),
        .i_clear_to_send_b(cts_b), .i_rx_done(rx_done), .i_rx_char(rx_char),
        .i_rx_parity_bit(rx_par), .i_rx_stop_ok(stop_ok), .i_tx_load(tx_load),
        .o_tx_data(o_tx_data), .o_tx_parity_bit(o_tx_parity_bit),
        .o_tx_pending(o_tx_pending), .o_divide_select(o_divide_select),
        .o_word_select(o_word_select), .o_tx_control(o_tx_control),
        .o_master_reset(o_master_reset));
    usf_far_model u_far (.i_mclk(i_mclk), .i_slow(slow), .i_tx_pending(o_tx_pending),
        .o_carrier_b(car_b), .o_clear_to_send_b(cts_b), .o_rx_done(rx_done),
        .o_rx_char(rx_char), .o_rx_parity_bit(rx_par), .o_rx_stop_ok(stop_ok),
        .o_tx_load(tx_load));

    // 100 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // ****
    // Tasks
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One bus access; read data is registered on the taking edge and sampled at the next falling edge
    task automatic access(input logic sel, input logic r, input logic [7:0] d);
        @(negedge i_mclk);
        i_access = 1'b1;
        rs = sel;
        rd = r;
        wd = d;
        @(negedge i_mclk);
        i_access = 1'b0;
        got = o_rdata;
    endtask
    task automatic stat(input logic [7:0] exp);
        access(1'b0, 1'b1, 8'h00);
        check(got, exp);
        check({7'h0, o_data_oe}, 8'h01);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // Bounded wait for the shifter to take the holding register
    task automatic wait_tx();
        int n;
        n = 0;
        while (o_tx_pending === 1'b1 && n < 40) begin
            @(negedge i_mclk);
            n++;
        end
        if (n == 40) begin
            n_fail++;
            $display("Error at %0t: transmit load timed out", $time);
            give_verdict();
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        {i_rst_b, i_access, rs, rd, slow, wd} = 13'h0;
        n_fail = 0;
        checks = 0;
        idle(16);
        check({7'h0, o_master_reset}, 8'h01);
        i_rst_b = 1'b1;
        access(1'b0, 1'b0, 8'h95);
        idle(2);
        stat(8'h02);
        $display("test reset done");
        // Slow shifter so the full holding register is seen
        slow = 1'b1;
        access(1'b1, 1'b0, 8'h5a);
        check(o_tx_data, 8'h5a);
        stat(8'h00);
        wait_tx();
        idle(1);
        stat(8'h02);
        slow = 1'b0;
        $display("test transmit done");
        u_far.send_char(8'ha5, 1'b0, 1'b1);
        idle(3);
        check({7'h0, o_irq_b}, 8'h00);
        stat(8'h83);
        access(1'b1, 1'b1, 8'h00);
        check(got, 8'ha5);
        idle(2);
        stat(8'h02);
        check({7'h0, o_irq_b}, 8'h01);
        $display("test receive done");
        // Every word format, with a bad stop bit in even codes
        for (int w = 0; w < 8; w++) begin
            access(1'b0, 1'b0, {3'h0, w[2:0], 2'h1});
            u_far.send_char(8'h83, 1'b0, w[0]);
            want = {1'b0, !w[0] ? 7'h13 : 7'h03};
            if (w < 4 && w[0] || w == 6) want[6] = 1'b1;
            idle(2);
            stat(want);
            idle(3);
            stat(want);
            access(1'b1, 1'b1, 8'h00);
            access(1'b1, 1'b0, 8'h83);
            wait_tx();
        end
        $display("test formats done");
        access(1'b0, 1'b0, 8'h95);
        u_far.send_char(8'h11, 1'b0, 1'b1);
        idle(2);
        u_far.send_char(8'h22, 1'b0, 1'b1);
        idle(2);
        stat(8'h83);
        access(1'b1, 1'b1, 8'h00);
        check(got, 8'h11);
        stat(8'ha3);
        access(1'b1, 1'b1, 8'h00);
        idle(2);
        stat(8'h02);
        $display("test overrun done");
        u_far.set_modem(1'b1, 1'b0);
        idle(3);
        u_far.set_modem(1'b0, 1'b0);
        idle(2);
        access(1'b1, 1'b1, 8'h00);
        idle(2);
        stat(8'h86);
        access(1'b1, 1'b1, 8'h00);
        idle(2);
        stat(8'h02);
        u_far.set_modem(1'b1, 1'b0);
        idle(3);
        stat(8'h86);
        access(1'b1, 1'b1, 8'h00);
        idle(2);
        stat(8'h06);
        $display("test carrier done");
        u_far.set_modem(1'b1, 1'b1);
        idle(3);
        access(1'b0, 1'b0, 8'h03);
        idle(2);
        stat(8'h0c);
        u_far.set_modem(1'b0, 1'b0);
        access(1'b0, 1'b0, 8'h95);
        idle(3);
        stat(8'h02);
        access(1'b0, 1'b0, 8'h35);
        idle(2);
        check({6'h0, o_tx_control, o_irq_b}, 8'h02);
        access(1'b1, 1'b0, 8'h11);
        idle(1);
        check({7'h0, o_irq_b}, 8'h01);
        $display("test master reset done");
        give_verdict();
    end
endmodule

bind usf_flags usf_flags_chk u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_access(i_access), .i_register_select(i_register_select), .i_read(i_read),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq_b(o_irq_b), .i_carrier_b(i_carrier_b),
    .i_clear_to_send_b(i_clear_to_send_b), .i_tx_load(i_tx_load), .o_tx_data(o_tx_data),
    .o_tx_parity_bit(o_tx_parity_bit), .o_tx_pending(o_tx_pending),
    .o_divide_select(o_divide_select), .o_word_select(o_word_select),
    .o_master_reset(o_master_reset));
`default_nettype wire
